// ==== hdl/rtc_calendar_alarm.sv ====
// calendar clock-watch with alarm match and interrupt merge
// ==========================================================
// Overview of operation
// RULE_01: seconds count 0..59 on each tick
// RULE_02: minutes count 0..59
// RULE_03: hours count 0..23
// RULE_04: weekday 1 Sunday through 7 Saturday
// RULE_05: day limit follows month and leap year
// RULE_06: month counts 1 January to 12 December
// RULE_07: separate year counter register
// RULE_08: software loads only legal calendar values
// RULE_09: load takes effect on next tick
// RULE_10: alarm when both match pairs agree
// RULE_11: zero year/month/day/weekday match is ignored
// RULE_12: alarm holds until software clears it
// RULE_13: timer irq on down-counter carry, sticky
// RULE_14: mask bit zero masks its source
// RULE_15: raw and masked status read-only
// RULE_16: output is OR of both interrupts
// RULE_17: calendar word field packing
// RULE_18: calendar resets to day1 month1 weekday1
// RULE_19: year counter resets to default
// RULE_20: year match resets to default, read/write
// RULE_21: out-of-range match field never matches
// RULE_22: overflow cascades up to the year
// RULE_23: tick divided from low-speed clock
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module rtc_calendar_alarm #(
  parameter int LS_DIV = rtc_pkg::LS_DIV_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic lsclk_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic timer_carry_i,
  input wire logic [31:0] timer_value_i,
  input wire logic [31:0] timer_irq_count_i,
  output logic [31:0] trim_ctrl_o,
  output logic [31:0] timer_ctrl_o,
  output logic [31:0] timer_reload1_o,
  output logic [31:0] timer_reload2_o,
  output logic [127:0] timer_pattern_o,
  output logic combined_irq_o
);
  import rtc_pkg::*;

  // elaboration check; the divider counter is only sixteen bits wide
  if (LS_DIV < 2 || LS_DIV > 65536) begin : g_div_check
    $error("LS_DIV out of range");
  end

  localparam logic [15:0] DIV_LAST = 16'(LS_DIV - 1);

  typedef struct packed {
    logic ls_meta;
    logic ls_sync;
    logic ls_prev;
    logic [15:0] div;
    logic tick;
    logic check;
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] wday;
    logic [4:0] mday;
    logic [3:0] mon;
    logic [13:0] year;
    logic [CAL_W-1:0] cal_match;
    logic [YEAR_W-1:0] year_match;
    logic [CAL_W-1:0] cal_load;
    logic [YEAR_W-1:0] year_load;
    logic load_pend;
    logic [31:0] trim;
    logic [1:0] mask;
    logic [1:0] raw;
    logic carry_prev;
    logic [31:0] tctrl;
    logic [31:0] reload1;
    logic [31:0] reload2;
    logic [127:0] pattern;
    logic [31:0] rdata;
    logic irq;
  } rtc_state_s;

  rtc_state_s st_ff;
  rtc_state_s nxt_st;

  // ==========================================================
  // calendar helpers
  function automatic logic rtc_mult4(input logic [3:0] tens, input logic [3:0] units);
    logic u04;
    logic u26;
    u04 = (units == 4'h0) || (units == 4'h4) || (units == 4'h8);
    u26 = (units == 4'h2) || (units == 4'h6);
    return tens[0] ? u26 : u04;
  endfunction

  // bcd year; century years leap only when the century is a multiple of 4
  function automatic logic rtc_leap(input logic [13:0] y);
    logic [3:0] thou;
    thou = {2'h0, y[13:12]};
    if (y[7:0] == 8'h00) begin
      return rtc_mult4(thou, y[11:8]);
    end
    return rtc_mult4(y[7:4], y[3:0]);
  endfunction

  // RULE_05 month length lookup
  function automatic logic [4:0] rtc_mday_max(input logic [3:0] m, input logic leap);
    if (m == MON_FEB) begin
      return leap ? MDAY_FEB_LEAP : MDAY_FEB;
    end else if (m == MON_APR || m == MON_JUN || m == MON_SEP || m == MON_NOV) begin
      return MDAY_SHORT;
    end
    return MDAY_LONG;
  endfunction

  // bcd increment; top digit only has two bits so the year wraps to zero
  function automatic logic [13:0] rtc_year_inc(input logic [13:0] y);
    logic [13:0] r;
    r = y;
    if (r[3:0] != 4'h9) begin
      r[3:0] = r[3:0] + 4'h1;
      return r;
    end
    r[3:0] = 4'h0;
    if (r[7:4] != 4'h9) begin
      r[7:4] = r[7:4] + 4'h1;
      return r;
    end
    r[7:4] = 4'h0;
    if (r[11:8] != 4'h9) begin
      r[11:8] = r[11:8] + 4'h1;
      return r;
    end
    r[11:8] = 4'h0;
    r[13:12] = r[13:12] + 2'h1;
    return r;
  endfunction

  // ==========================================================
  // combinational next state
  logic [CAL_W-1:0] cal_now;
  logic ls_rise;
  logic cal_hit;
  logic year_hit;
  logic alarm_set;
  logic timer_set;
  logic [1:0] clr;
  logic [1:0] pat_idx;

  // RULE_17 calendar word packing
  assign cal_now = {st_ff.mon, st_ff.mday, st_ff.wday, st_ff.hour, st_ff.min, st_ff.sec};
  // prev resets low like the idle pin, so reset makes no false edge
  assign ls_rise = st_ff.ls_sync && !st_ff.ls_prev;

  always_comb begin
    logic [5:0] m_sec;
    logic [5:0] m_min;
    logic [4:0] m_hour;
    logic [2:0] m_wday;
    logic [4:0] m_mday;
    logic [3:0] m_mon;
    m_sec = st_ff.cal_match[SEC_LSB +: 6];
    m_min = st_ff.cal_match[MIN_LSB +: 6];
    m_hour = st_ff.cal_match[HOUR_LSB +: 5];
    m_wday = st_ff.cal_match[WDAY_LSB +: 3];
    m_mday = st_ff.cal_match[MDAY_LSB +: 5];
    m_mon = st_ff.cal_match[MON_LSB +: 4];
    // RULE_11 zero weekday, day, month and year fields are wildcards
    // RULE_21 exact compare; counters never reach an illegal value
    cal_hit = (m_sec == st_ff.sec) && (m_min == st_ff.min) && (m_hour == st_ff.hour)
      && (m_wday == 3'h0 || m_wday == st_ff.wday)
      && (m_mday == 5'h00 || m_mday == st_ff.mday)
      && (m_mon == 4'h0 || m_mon == st_ff.mon);
    year_hit = (st_ff.year_match == 14'h0000) || (st_ff.year_match == st_ff.year);
  end

  // RULE_10 compare one cycle after the increment
  assign alarm_set = st_ff.check && cal_hit && year_hit;
  // RULE_13 carry rising edge marks zero reached
  assign timer_set = timer_carry_i && !st_ff.carry_prev;
  // a zero bit in the clear word leaves its flag alone
  assign clr = (wr_i && addr_i == OFS_IRQ_CLEAR) ? wdata_i[1:0] : 2'h0;
  // pattern words 0x3c..0x48 wrap to index 0..3;
  // kept two bits wide so the word offset can never go negative
  assign pat_idx = addr_i[3:2] - OFS_TMR_PAT0[3:2];

  always_comb begin
    nxt_st = st_ff;
    // RULE_23 two-flop sync, then edge count
    nxt_st.ls_meta = lsclk_i;
    nxt_st.ls_sync = st_ff.ls_meta;
    nxt_st.ls_prev = st_ff.ls_sync;
    nxt_st.tick = 1'b0;
    nxt_st.check = 1'b0;
    nxt_st.carry_prev = timer_carry_i;
    if (ls_rise) begin
      if (st_ff.div == DIV_LAST) begin
        nxt_st.div = 16'h0000;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.div = st_ff.div + 16'h0001;
      end
    end

    // ==========================================================
    // calendar counting
    if (st_ff.tick) begin
      if (st_ff.load_pend) begin
        // no compare on a load tick, nothing was incremented
        // RULE_09 pending load copied on the tick
        nxt_st.load_pend = 1'b0;
        nxt_st.sec = st_ff.cal_load[SEC_LSB +: 6];
        nxt_st.min = st_ff.cal_load[MIN_LSB +: 6];
        nxt_st.hour = st_ff.cal_load[HOUR_LSB +: 5];
        nxt_st.wday = st_ff.cal_load[WDAY_LSB +: 3];
        nxt_st.mday = st_ff.cal_load[MDAY_LSB +: 5];
        nxt_st.mon = st_ff.cal_load[MON_LSB +: 4];
        nxt_st.year = st_ff.year_load;
      end else begin
        nxt_st.check = 1'b1;
        // RULE_01 seconds
        // RULE_22 cascade on overflow
        if (st_ff.sec != SEC_MAX) begin
          nxt_st.sec = st_ff.sec + 6'h01;
        end else begin
          nxt_st.sec = 6'h00;
          // RULE_02 minutes
          if (st_ff.min != MIN_MAX) begin
            nxt_st.min = st_ff.min + 6'h01;
          end else begin
            nxt_st.min = 6'h00;
            // RULE_03 hours
            if (st_ff.hour != HOUR_MAX) begin
              nxt_st.hour = st_ff.hour + 5'h01;
            end else begin
              nxt_st.hour = 5'h00;
              // RULE_04 weekday wraps to Sunday
              nxt_st.wday = (st_ff.wday == WDAY_MAX) ? WDAY_FIRST : st_ff.wday + 3'h1;
              // RULE_05 month-dependent day limit
              if (st_ff.mday != rtc_mday_max(st_ff.mon, rtc_leap(st_ff.year))) begin
                nxt_st.mday = st_ff.mday + 5'h01;
              end else begin
                nxt_st.mday = MDAY_FIRST;
                // RULE_06 month wrap
                if (st_ff.mon != MON_MAX) begin
                  nxt_st.mon = st_ff.mon + 4'h1;
                end else begin
                  nxt_st.mon = MON_FIRST;
                  // RULE_07 year count
                  nxt_st.year = rtc_year_inc(st_ff.year);
                end
              end
            end
          end
        end
      end
    end

    // ==========================================================
    // register writes
    if (wr_i) begin
      if (addr_i == OFS_CAL_MATCH) begin
        nxt_st.cal_match = wdata_i[CAL_W-1:0];
      end else if (addr_i == OFS_CAL_LOAD) begin
        nxt_st.cal_load = wdata_i[CAL_W-1:0];
        nxt_st.load_pend = 1'b1;
      end else if (addr_i == OFS_YEAR_MATCH) begin
        // RULE_20 year match writable
        nxt_st.year_match = wdata_i[YEAR_W-1:0];
      end else if (addr_i == OFS_YEAR_LOAD) begin
        nxt_st.year_load = wdata_i[YEAR_W-1:0];
        nxt_st.load_pend = 1'b1;
      end else if (addr_i == OFS_TRIM_CTRL) begin
        nxt_st.trim = wdata_i;
      end else if (addr_i == OFS_IRQ_MASK) begin
        nxt_st.mask = wdata_i[1:0];
      end else if (addr_i == OFS_TMR_CTRL) begin
        nxt_st.tctrl = wdata_i;
      end else if (addr_i == OFS_TMR_RELOAD1) begin
        nxt_st.reload1 = wdata_i;
      end else if (addr_i == OFS_TMR_RELOAD2) begin
        nxt_st.reload2 = wdata_i;
      end else if (addr_i >= OFS_TMR_PAT0 && addr_i <= OFS_TMR_PAT3) begin
        nxt_st.pattern[{pat_idx, 5'h00} +: 32] = wdata_i;
      end
    end

    // ==========================================================
    // interrupt status; a set in the clearing cycle wins
    // RULE_12 alarm sticky until cleared
    nxt_st.raw[IRQ_ALARM] = alarm_set || (st_ff.raw[IRQ_ALARM] && !clr[IRQ_ALARM]);
    // RULE_13 timer sticky until cleared
    nxt_st.raw[IRQ_TIMER] = timer_set || (st_ff.raw[IRQ_TIMER] && !clr[IRQ_TIMER]);
    // RULE_14 mask gates each source
    // RULE_16 single OR output
    nxt_st.irq = |(nxt_st.raw & nxt_st.mask);

    // ==========================================================
    // read data, valid the cycle after the strobe
    nxt_st.rdata = 32'h00000000;
    if (rd_i) begin
      if (addr_i == OFS_CAL_COUNT) begin
        nxt_st.rdata = {3'h0, cal_now};
      end else if (addr_i == OFS_CAL_MATCH) begin
        nxt_st.rdata = {3'h0, st_ff.cal_match};
      end else if (addr_i == OFS_CAL_LOAD) begin
        nxt_st.rdata = {3'h0, st_ff.cal_load};
      end else if (addr_i == OFS_YEAR_COUNT) begin
        nxt_st.rdata = {18'h00000, st_ff.year};
      end else if (addr_i == OFS_YEAR_MATCH) begin
        nxt_st.rdata = {18'h00000, st_ff.year_match};
      end else if (addr_i == OFS_YEAR_LOAD) begin
        nxt_st.rdata = {18'h00000, st_ff.year_load};
      end else if (addr_i == OFS_TRIM_CTRL) begin
        nxt_st.rdata = st_ff.trim;
      end else if (addr_i == OFS_IRQ_MASK) begin
        nxt_st.rdata = {30'h00000000, st_ff.mask};
      end else if (addr_i == OFS_IRQ_RAW) begin
        // RULE_15 pre-mask status
        nxt_st.rdata = {30'h00000000, st_ff.raw};
      end else if (addr_i == OFS_IRQ_MASKED) begin
        // RULE_15 post-mask status
        nxt_st.rdata = {30'h00000000, st_ff.raw & st_ff.mask};
      end else if (addr_i == OFS_TMR_VALUE) begin
        nxt_st.rdata = timer_value_i;
      end else if (addr_i == OFS_TMR_CTRL) begin
        nxt_st.rdata = st_ff.tctrl;
      end else if (addr_i == OFS_TMR_RELOAD1) begin
        nxt_st.rdata = st_ff.reload1;
      end else if (addr_i == OFS_TMR_RELOAD2) begin
        nxt_st.rdata = st_ff.reload2;
      end else if (addr_i >= OFS_TMR_PAT0 && addr_i <= OFS_TMR_PAT3) begin
        nxt_st.rdata = st_ff.pattern[{pat_idx, 5'h00} +: 32];
      end else if (addr_i == OFS_TMR_IRQ_CNT) begin
        nxt_st.rdata = timer_irq_count_i;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= '0;
      // RULE_18 calendar reset value
      st_ff.wday <= WDAY_FIRST;
      st_ff.mday <= MDAY_FIRST;
      st_ff.mon <= MON_FIRST;
      // RULE_19 year reset value
      st_ff.year <= YEAR_RST;
      // RULE_20 year match reset value
      st_ff.year_match <= YEAR_RST;
      st_ff.trim <= TRIM_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign combined_irq_o = st_ff.irq;
  assign trim_ctrl_o = st_ff.trim;
  assign timer_ctrl_o = st_ff.tctrl;
  assign timer_reload1_o = st_ff.reload1;
  assign timer_reload2_o = st_ff.reload2;
  assign timer_pattern_o = st_ff.pattern;
endmodule

// ==== hdl/rtc_pkg.sv ====
// constants for the calendar clock-watch unit
package rtc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CAL_COUNT = 8'h00;
  localparam logic [7:0] OFS_CAL_MATCH = 8'h04;
  localparam logic [7:0] OFS_CAL_LOAD = 8'h08;
  localparam logic [7:0] OFS_YEAR_COUNT = 8'h0c;
  localparam logic [7:0] OFS_YEAR_MATCH = 8'h10;
  localparam logic [7:0] OFS_YEAR_LOAD = 8'h14;
  localparam logic [7:0] OFS_TRIM_CTRL = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_IRQ_RAW = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASKED = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] OFS_TMR_VALUE = 8'h2c;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h30;
  localparam logic [7:0] OFS_TMR_RELOAD1 = 8'h34;
  localparam logic [7:0] OFS_TMR_RELOAD2 = 8'h38;
  localparam logic [7:0] OFS_TMR_PAT0 = 8'h3c;
  localparam logic [7:0] OFS_TMR_PAT3 = 8'h48;
  localparam logic [7:0] OFS_TMR_IRQ_CNT = 8'h4c;
  // ==========================================================
  // calendar word layout
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 6;
  localparam int HOUR_LSB = 12;
  localparam int WDAY_LSB = 17;
  localparam int MDAY_LSB = 20;
  localparam int MON_LSB = 25;
  localparam int CAL_W = 29;
  localparam int YEAR_W = 14;
  // ==========================================================
  // limits and reset values
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [2:0] WDAY_MAX = 3'h7;
  localparam logic [2:0] WDAY_FIRST = 3'h1;
  localparam logic [4:0] MDAY_FIRST = 5'h01;
  localparam logic [3:0] MON_FIRST = 4'h1;
  localparam logic [3:0] MON_MAX = 4'hc;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [3:0] MON_APR = 4'h4;
  localparam logic [3:0] MON_JUN = 4'h6;
  localparam logic [3:0] MON_SEP = 4'h9;
  localparam logic [3:0] MON_NOV = 4'hb;
  localparam logic [4:0] MDAY_LONG = 5'h1f;
  localparam logic [4:0] MDAY_SHORT = 5'h1e;
  localparam logic [4:0] MDAY_FEB_LEAP = 5'h1d;
  localparam logic [4:0] MDAY_FEB = 5'h1c;
  localparam logic [13:0] YEAR_RST = 14'h2000;
  localparam logic [31:0] TRIM_RST = 32'h00007fff;
  // ==========================================================
  // interrupt bit positions and default tick divider
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_TIMER = 1;
  localparam int LS_DIV_DEF = 32768;
endpackage

// ==== tb/rtc_calendar_alarm_properties.sv ====
// port assertions for the calendar clock-watch unit
`timescale 1ns/1ns
module rtc_calendar_alarm_properties
  import rtc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic timer_carry_i,
  input wire logic [31:0] timer_value_i,
  input wire logic [31:0] timer_irq_count_i,
  input wire logic combined_irq_o
);
  // ==========================================================
  // mask shadow, rebuilt from bus writes
  logic [1:0] msk_ff;
  logic mw;
  logic cw;
  assign mw = wr_i && addr_i == OFS_IRQ_MASK;
  assign cw = wr_i && addr_i == OFS_IRQ_CLEAR && wdata_i[1:0] != 2'h0;
  always_ff @(posedge clk_sys_i) begin
    msk_ff <= rst_i ? 2'h0 : (mw ? wdata_i[1:0] : msk_ff);
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  a_timer_irq_set: assert property ($rose(timer_carry_i) && msk_ff[1] && !mw |=> combined_irq_o)
    else $error("timer carry did not raise the interrupt");
  a_irq_sticky: assert property (combined_irq_o && !cw && !mw |=> combined_irq_o)
    else $error("interrupt dropped without a clear");
  a_masked_quiet: assert property (msk_ff == 2'h0 && !mw |=> !combined_irq_o)
    else $error("interrupt seen with both sources masked");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  a_clear_reads_zero: assert property (rd_i && addr_i == OFS_IRQ_CLEAR |=> rdata_o == 32'h0)
    else $error("clear register read back nonzero");
  a_timer_value_read: assert property (rd_i && addr_i == OFS_TMR_VALUE
    |=> rdata_o == $past(timer_value_i))
    else $error("timer value read mismatch");
  a_irq_count_read: assert property (rd_i && addr_i == OFS_TMR_IRQ_CNT
    |=> rdata_o == $past(timer_irq_count_i))
    else $error("timer count read mismatch");
  a_year_match_rw: assert property (wr_i && addr_i == OFS_YEAR_MATCH ##1 rd_i
    && addr_i == OFS_YEAR_MATCH |=> rdata_o == {18'h0, $past(wdata_i[13:0], 2)})
    else $error("year match read back mismatch");
endmodule
bind rtc_calendar_alarm rtc_calendar_alarm_properties u_props (.clk_sys_i, .rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .timer_carry_i, .timer_value_i, .timer_irq_count_i,
  .combined_irq_o);

// ==== tb/rtc_calendar_alarm_tb_top.sv ====
// self-checking bench for the calendar clock-watch unit
`timescale 1ns/1ns
module rtc_calendar_alarm_tb_top;
  import rtc_pkg::*;
  localparam int DIV = 4;
  logic clk_sys_i = 0, rst_i = 1, lsclk_i = 0, ls_en = 0, wr_i = 0, rd_i = 0;
  logic timer_carry_i = 0, combined_irq_o;
  logic [7:0] addr_i = 0;
  logic [31:0] wdata_i = 0, timer_value_i = 0, timer_irq_count_i = 0, rdata_o, d, w;
  logic [31:0] trim_ctrl_o, timer_ctrl_o, timer_reload1_o, timer_reload2_o, m;
  logic [127:0] timer_pattern_o;
  logic [31:0] st [6], ex [6], wv [11];
  logic [13:0] ys [6], ye [6];
  logic [7:0] ro [6], rw [11];
  int fail_count = 0, cmp_count = 0;
  rtc_calendar_alarm #(.LS_DIV(DIV)) uut (.clk_sys_i, .rst_i, .lsclk_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .timer_carry_i, .timer_value_i, .timer_irq_count_i, .trim_ctrl_o,
    .timer_ctrl_o, .timer_reload1_o, .timer_reload2_o, .timer_pattern_o, .combined_irq_o);
  always #4 clk_sys_i = ~clk_sys_i;
  int ls_cnt = 0;
  // low-speed clock sped up: a tick costs about a hundred system cycles
  always @(posedge clk_sys_i) begin
    ls_cnt <= (ls_cnt == 12) ? 0 : ls_cnt + 1;
    if (ls_en && ls_cnt == 12) begin
      lsclk_i <= ~lsclk_i;
    end
  end
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_sys_i);
    wr_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 0;
    #1 v = rdata_o;
  endtask
  // write then read back with no idle cycle between the strobes
  task automatic wrrd(input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
    @(posedge clk_sys_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_sys_i);
    wr_i <= 0;
    rd_i <= 1;
    @(posedge clk_sys_i);
    rd_i <= 0;
    #1 r = rdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    rd(a, v);
    chk(nm, v, e);
  endtask
  // bounded poll until the calendar word moves
  task automatic wait_tick(output logic [31:0] v);
    logic [31:0] v0;
    rd(OFS_CAL_COUNT, v0);
    v = v0;
    for (int n = 0; n < 300 && v === v0; n++) rd(OFS_CAL_COUNT, v);
  endtask
  function automatic logic [31:0] pk(int s, int mi, int h, int wd, int md, int mo);
    return {3'h0, 4'(mo), 5'(md), 3'(wd), 5'(h), 6'(mi), 6'(s)};
  endfunction
  function automatic logic [31:0] rexp(logic [7:0] a);
    case (a)
      OFS_CAL_COUNT: return 32'h02120000;
      OFS_YEAR_COUNT, OFS_YEAR_MATCH: return 32'h00002000;
      OFS_TRIM_CTRL: return 32'h00007fff;
      OFS_TMR_VALUE: return timer_value_i;
      OFS_TMR_IRQ_CNT: return timer_irq_count_i;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] wmask(logic [7:0] a);
    case (a)
      OFS_CAL_MATCH: return 32'h1fffffff;
      OFS_YEAR_MATCH: return 32'h00003fff;
      OFS_IRQ_MASK: return 32'h00000003;
      default: return 32'hffffffff;
    endcase
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  // ==========================================================
  initial begin
    void'($urandom(21929));
    timer_value_i <= $urandom;
    timer_irq_count_i <= $urandom;
    ro = '{8'h00, 8'h0c, 8'h20, 8'h24, 8'h2c, 8'h4c};
    rw = '{8'h04, 8'h10, 8'h18, 8'h1c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48};
    // leap, century and bcd carries among the table
    // loads hold legal values only
    st = '{pk(30, 20, 10, 3, 15, 6), pk(59, 59, 23, 7, 28, 2), pk(59, 59, 23, 4, 29, 2),
      pk(59, 59, 23, 2, 28, 2), pk(59, 59, 23, 6, 30, 4), pk(59, 59, 23, 1, 31, 12)};
    ex = '{pk(31, 20, 10, 3, 15, 6), pk(0, 0, 0, 1, 29, 2), pk(0, 0, 0, 5, 1, 3),
      pk(0, 0, 0, 3, 1, 3), pk(0, 0, 0, 7, 1, 5), pk(0, 0, 0, 2, 1, 1)};
    ys = '{14'h2024, 14'h2000, 14'h2000, 14'h2100, 14'h2023, 14'h2099};
    ye = '{14'h2024, 14'h2000, 14'h2000, 14'h2100, 14'h2023, 14'h2100};
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 0;
    for (int k = 0; k < 6; k++) wr(ro[k], $urandom);
    for (int a = 0; a <= 8'h50; a += 4) rchk(8'(a), rexp(8'(a)), "reset");
    chk("trim reset", trim_ctrl_o, 32'h00007fff);
    $display("test reset values done");
    for (int k = 0; k < 11; k++) begin
      wv[k] = $urandom;
      wrrd(rw[k], wv[k], w);
      chk("rw", w, wv[k] & wmask(rw[k]));
    end
    chk("trim port", trim_ctrl_o, wv[2]);
    chk("tctrl port", timer_ctrl_o, wv[4]);
    chk("reload1 port", timer_reload1_o, wv[5]);
    chk("reload2 port", timer_reload2_o, wv[6]);
    for (int k = 0; k < 4; k++) chk("pattern port", timer_pattern_o[32*k +: 32], wv[7+k]);
    wr(OFS_IRQ_MASK, 32'h0);
    $display("test register access done");
    for (int i = 0; i < 6; i++) begin
      m = i[0] ? ex[i] & 32'h0001ffff : ex[i];
      wr(OFS_CAL_MATCH, m);
      wr(OFS_YEAR_MATCH, i[0] ? 32'h0 : {18'h0, ye[i]});
      wr(OFS_IRQ_MASK, {31'h0, i[1]});
      wr(OFS_CAL_LOAD, st[i]);
      wr(OFS_YEAR_LOAD, {18'h0, ys[i]});
      rchk(OFS_CAL_LOAD, st[i], "load reg");
      ls_en = 1;
      wait_tick(w);
      chk("loaded", w, st[i]);
      rchk(OFS_YEAR_COUNT, {18'h0, ys[i]}, "year load");
      wait_tick(w);
      ls_en = 0;
      chk("next second", w, ex[i]);
      rchk(OFS_YEAR_COUNT, {18'h0, ye[i]}, "year next");
      repeat (4) @(posedge clk_sys_i);
      #1 chk("irq", {31'h0, combined_irq_o}, {31'h0, i[1]});
      rchk(OFS_IRQ_RAW, 32'h1, "raw alarm");
      rchk(OFS_IRQ_MASKED, {31'h0, i[1]}, "masked alarm");
      wr(OFS_IRQ_CLEAR, 32'h1);
      rchk(OFS_IRQ_RAW, 32'h0, "raw cleared");
    end
    // seconds match of 60 must never fire
    wr(OFS_CAL_MATCH, 32'h0000003c);
    wr(OFS_YEAR_MATCH, 32'h0);
    ls_en = 1;
    wait_tick(w);
    wait_tick(w);
    ls_en = 0;
    chk("count on", w, pk(2, 0, 0, 2, 1, 1));
    repeat (4) @(posedge clk_sys_i);
    rchk(OFS_IRQ_RAW, 32'h0, "bad match");
    $display("test calendar and alarm done");
    for (int j = 0; j < 2; j++) begin
      wr(OFS_IRQ_MASK, j ? 32'h0 : 32'h2);
      @(posedge clk_sys_i);
      timer_carry_i <= 1;
      @(posedge clk_sys_i);
      timer_carry_i <= 0;
      repeat (2) @(posedge clk_sys_i);
      #1 chk("timer irq", {31'h0, combined_irq_o}, j ? 32'h0 : 32'h1);
      rchk(OFS_IRQ_RAW, 32'h2, "raw timer");
      rchk(OFS_IRQ_MASKED, j ? 32'h0 : 32'h2, "masked timer");
      wr(OFS_IRQ_CLEAR, 32'h2);
      rchk(OFS_IRQ_RAW, 32'h0, "timer cleared");
    end
    $display("test timer interrupt done");
    complete_run();
  end
endmodule
